// file: verilog/dcs_clock_switch.sv
/*
 * CPU clock source switch, divider, oscillator enables and watchdog.
 * Assumes control bits come from logic on clk; oscillator outputs are async pins.
 * CPU and peripheral clocks are delivered as one-cycle tick pulses on clk.
 */
`default_nettype none
module dcs_clock_switch #(
    parameter logic [15:0] WDOG_OVERFLOW = dcs_pkg::WDOG_OVERFLOW_DEF
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic crystal_clk_pin,
    input wire logic ring_clk_pin,
    input wire logic ring_stoppable_opt,
    input wire logic cpu_source_select,
    input wire logic crystal_stop_ctrl, // Bit 7 of crystal control
    input wire logic ring_stop_ctrl, // Bit 0 of ring mode
    input wire logic [2:0] cpu_div_sel,
    input wire logic stop_enter,
    input wire logic stop_release_irq,
    input wire logic halt_mode,
    input wire logic stab_wait_done,
    input wire logic watchdog_clear,
    output logic cpu_clk_tick,
    output logic periph_clk_tick,
    output logic cpu_source_status,
    output logic [2:0] cpu_div_active,
    output logic crystal_osc_en,
    output logic internal_ring_oscillator_en,
    output logic cpu_clock_held,
    output logic watchdog_reset_req
);
    ////////////////////////////////////////////////////////////////////////////////
    // Oscillator sampling

    logic xtal_edge;
    logic ring_edge;

    dcs_osc_edge u_xtal_edge (
        .clk(clk),
        .arst_n(arst_n),
        .osc_pin(crystal_clk_pin),
        .rise_pulse(xtal_edge)
    );

    dcs_osc_edge u_ring_edge (
        .clk(clk),
        .arst_n(arst_n),
        .osc_pin(ring_clk_pin),
        .rise_pulse(ring_edge)
    );

    // Prohibited codes above the largest divider fall back to it
    function automatic logic [3:0] div_last(input logic [2:0] code);
        logic [2:0] c;
        c = (code > dcs_pkg::DIV_CODE_MAX) ? dcs_pkg::DIV_CODE_MAX : code;
        div_last = 4'((5'h01 << c) - 5'h01);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    dcs_pkg::dcs_state_type state_ff, nxt_state;
    logic src_ff, nxt_src;
    logic [1:0] pend_ff, nxt_pend;
    logic [2:0] div_ff, nxt_div;
    logic [3:0] div_cnt_ff, nxt_div_cnt;
    logic [4:0] start_cnt_ff, nxt_start_cnt;
    logic cpu_tick_ff, nxt_cpu_tick;
    logic per_tick_ff, nxt_per_tick;
    logic xtal_en_ff, nxt_xtal_en;
    logic ring_en_ff, nxt_ring_en;
    logic [15:0] wdog_ff, nxt_wdog;
    logic wdog_rst_ff, nxt_wdog_rst;

    logic src_tick;
    logic running;
    logic tick_now;
    logic [1:0] need;
    logic per_src;
    logic asleep;

    always_comb begin
        nxt_state = state_ff;
        nxt_src = src_ff;
        nxt_pend = pend_ff;
        nxt_div = div_ff;
        nxt_div_cnt = div_cnt_ff;
        nxt_start_cnt = start_cnt_ff;

        src_tick = (src_ff == dcs_pkg::SRC_XTAL) ? xtal_edge : ring_edge;
        running = (state_ff == dcs_pkg::ST_RUN) && !halt_mode;
        tick_now = running && src_tick && (div_cnt_ff == div_last(div_ff));
        need = (src_ff == dcs_pkg::SRC_XTAL) ? dcs_pkg::SW_TO_RING_CLKS : dcs_pkg::SW_TO_XTAL_CLKS;

        // Divider counts source edges; a CPU tick ends each divided period
        if (running && src_tick) begin
            nxt_div_cnt = tick_now ? 4'h0 : div_cnt_ff + 4'h1;
        end

        if (tick_now) begin
            // New divider only at a period boundary, so old period completes
            nxt_div = cpu_div_sel;
            if (cpu_source_select != src_ff) begin
                // Keep old source for the pre-switch clocks, then swap at a boundary
                if (pend_ff + 2'h1 == need) begin
                    nxt_src = cpu_source_select;
                    nxt_pend = 2'h0;
                end else begin
                    nxt_pend = pend_ff + 2'h1;
                end
            end else begin
                nxt_pend = 2'h0;
            end
        end

        unique case (state_ff)
            dcs_pkg::ST_STARTUP: begin
                // Withhold CPU clock for the startup ring clocks
                if (ring_edge) begin
                    nxt_start_cnt = start_cnt_ff + 5'h01;
                    if (start_cnt_ff + 5'h01 == dcs_pkg::STARTUP_RING_CLKS) begin
                        nxt_state = dcs_pkg::ST_RUN;
                    end
                end
            end
            dcs_pkg::ST_RUN: begin
                if (stop_enter) begin
                    nxt_state = dcs_pkg::ST_STOP;
                end
            end
            dcs_pkg::ST_STOP: begin
                // Source register untouched, so release resumes it
                if (stop_release_irq) begin
                    // Stabilization wait only for interrupt release on crystal
                    nxt_state = (src_ff == dcs_pkg::SRC_XTAL) ? dcs_pkg::ST_STAB : dcs_pkg::ST_RUN;
                    nxt_div_cnt = 4'h0;
                end
            end
            dcs_pkg::ST_STAB: begin
                if (stab_wait_done) begin
                    nxt_state = dcs_pkg::ST_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= dcs_pkg::ST_STARTUP;
            src_ff <= dcs_pkg::SRC_RING;
            pend_ff <= 2'h0;
            div_ff <= 3'h0;
            div_cnt_ff <= 4'h0;
            start_cnt_ff <= 5'h00;
        end else begin
            state_ff <= nxt_state;
            src_ff <= nxt_src;
            pend_ff <= nxt_pend;
            div_ff <= nxt_div;
            div_cnt_ff <= nxt_div_cnt;
            start_cnt_ff <= nxt_start_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tick outputs, oscillator enables

    always_comb begin
        nxt_cpu_tick = tick_now;
        // HALT feeds the prescaler from the select bit; otherwise from the live source
        per_src = halt_mode ? cpu_source_select : src_ff;
        // Prescaler stopped in reset, startup, STOP and STAB
        nxt_per_tick = (state_ff == dcs_pkg::ST_RUN) &&
                       ((per_src == dcs_pkg::SRC_XTAL) ? xtal_edge : ring_edge);
        // Crystal stops in STOP or on its stop bit, never while it drives the CPU
        nxt_xtal_en = (state_ff != dcs_pkg::ST_STOP) &&
                      !(crystal_stop_ctrl && (src_ff == dcs_pkg::SRC_RING) && (nxt_src == dcs_pkg::SRC_RING));
        // Ring stop needs the option and the CPU on crystal, even in STOP; both stops set keeps the ring
        nxt_ring_en = !(ring_stoppable_opt && ring_stop_ctrl && !crystal_stop_ctrl &&
                        (src_ff == dcs_pkg::SRC_XTAL) && (nxt_src == dcs_pkg::SRC_XTAL));
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            // Both oscillators held off during reset
            cpu_tick_ff <= 1'b0;
            per_tick_ff <= 1'b0;
            xtal_en_ff <= 1'b0;
            ring_en_ff <= 1'b0;
        end else begin
            cpu_tick_ff <= nxt_cpu_tick;
            per_tick_ff <= nxt_per_tick;
            xtal_en_ff <= nxt_xtal_en;
            ring_en_ff <= nxt_ring_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog on ring clock

    always_comb begin
        asleep = halt_mode || (state_ff == dcs_pkg::ST_STOP) || (state_ff == dcs_pkg::ST_STAB);
        nxt_wdog = wdog_ff;
        nxt_wdog_rst = wdog_rst_ff;
        if (watchdog_clear) begin
            nxt_wdog = 16'h0000;
        end else if (ring_edge && !(ring_stoppable_opt && asleep)) begin
            // Fixed ring keeps counting through STOP
            if (wdog_ff == WDOG_OVERFLOW) begin
                nxt_wdog_rst = 1'b1;
            end else begin
                nxt_wdog = wdog_ff + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdog_ff <= 16'h0000;
            wdog_rst_ff <= 1'b0;
        end else begin
            wdog_ff <= nxt_wdog;
            wdog_rst_ff <= nxt_wdog_rst;
        end
    end

    assign cpu_clk_tick = cpu_tick_ff;
    assign periph_clk_tick = per_tick_ff;
    assign cpu_source_status = src_ff;
    assign cpu_div_active = div_ff;
    assign crystal_osc_en = xtal_en_ff;
    assign internal_ring_oscillator_en = ring_en_ff;
    assign cpu_clock_held = (state_ff != dcs_pkg::ST_RUN);
    assign watchdog_reset_req = wdog_rst_ff;
endmodule
`default_nettype wire

// file: include/dcs_pkg.sv
/*
 * Constants and types for the dual oscillator clock switch.
 * Assumes a single 250 MHz system clock that samples both oscillator outputs.
 */
`default_nettype none
package dcs_pkg;
    localparam int unsigned SYS_CLK_MHZ = 250;
    localparam logic [4:0] STARTUP_RING_CLKS = 5'h11;
    localparam logic [1:0] SW_TO_XTAL_CLKS = 2'h2;
    localparam logic [1:0] SW_TO_RING_CLKS = 2'h1;
    localparam logic [2:0] DIV_CODE_MAX = 3'h4;
    localparam int unsigned DIV_W = 3;
    localparam int unsigned DIV_CNT_W = 4;
    localparam int unsigned WDOG_W = 16;
    localparam logic [WDOG_W-1:0] WDOG_OVERFLOW_DEF = 16'hffff;
    localparam logic SRC_RING = 1'b0;
    localparam logic SRC_XTAL = 1'b1;

    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_RUN = 2'b01,
        ST_STOP = 2'b10,
        ST_STAB = 2'b11
    } dcs_state_type;
endpackage
`default_nettype wire

// file: verilog/dcs_osc_edge.sv
/*
 * Oscillator edge sampler: two-flop synchroniser then rising-edge pulse.
 * Assumes the oscillator runs well below half the system clock.
 */
`default_nettype none
module dcs_osc_edge (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic osc_pin,
    output logic rise_pulse
);
    logic meta_ff;
    logic sync_ff;
    logic last_ff;
    logic nxt_meta;
    logic nxt_sync;
    logic nxt_last;

    always_comb begin
        nxt_meta = osc_pin;
        nxt_sync = meta_ff;
        nxt_last = sync_ff;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 1'b0;
            sync_ff <= 1'b0;
            last_ff <= 1'b0;
        end else begin
            meta_ff <= nxt_meta;
            sync_ff <= nxt_sync;
            last_ff <= nxt_last;
        end
    end

    // Edge compare only uses synchronised stages
    assign rise_pulse = sync_ff & ~last_ff;
endmodule
`default_nettype wire

// file: sim/dcs_clock_switch_asserts.sv
/* Port checks for the dcs_clock_switch.
   Bound from the bench top; one clk domain. */
`default_nettype none
module dcs_clock_switch_asserts (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ring_stoppable_opt,
    input wire logic cpu_source_select,
    input wire logic stop_enter,
    input wire logic halt_mode,
    input wire logic cpu_clk_tick,
    input wire logic periph_clk_tick,
    input wire logic cpu_source_status,
    input wire logic crystal_osc_en,
    input wire logic internal_ring_oscillator_en,
    input wire logic cpu_clock_held,
    input wire logic watchdog_reset_req
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////
    wdog_sticky_a: assert property (watchdog_reset_req |=> watchdog_reset_req)
        else $error("reset request dropped");
    ring_fixed_a: assert property (!ring_stoppable_opt [*2] |-> internal_ring_oscillator_en)
        else $error("fixed ring stopped");
    xtal_keep_a: assert property (cpu_source_status && !cpu_clock_held && !stop_enter
        ##1 cpu_source_status |-> crystal_osc_en) else $error("crystal stopped in use");
    held_quiet_a: assert property (cpu_clock_held [*2] |-> !cpu_clk_tick && !periph_clk_tick)
        else $error("tick while held");
    stop_entry_a: assert property (stop_enter && !cpu_clock_held |=> cpu_clock_held ##1 !crystal_osc_en)
        else $error("stop entry missed");
    halt_quiet_a: assert property (halt_mode [*3] |-> !cpu_clk_tick)
        else $error("cpu tick in halt");
    src_rise_a: assert property ($rose(cpu_source_status) |-> $past(cpu_source_select))
        else $error("status rose unasked");
    src_fall_a: assert property ($fell(cpu_source_status) |-> !$past(cpu_source_select))
        else $error("status fell unasked");
    cover property ($rose(cpu_source_status));
    cover property (stop_enter && !cpu_clock_held);
    cover property ($rose(watchdog_reset_req));
endmodule
`default_nettype wire

// file: sim/dcs_clock_switch_tb.sv
/* Bench for dcs_clock_switch: controls change on falling clk.
   Oscillator pins toggle only while their enable is high. */
`default_nettype none
module dcs_clock_switch_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int RP = 10;
    localparam int XP = 6;
    logic clk = 1'b0, arst_n = 1'b0, crystal_clk_pin = 1'b0, ring_clk_pin = 1'b0, ring_stoppable_opt = 1'b0;
    logic cpu_source_select = 1'b0, crystal_stop_ctrl = 1'b0, ring_stop_ctrl = 1'b0, stop_enter = 1'b0;
    logic stop_release_irq = 1'b0, halt_mode = 1'b0, stab_wait_done = 1'b0, watchdog_clear = 1'b0, wd_auto = 1'b1;
    logic [2:0] cpu_div_sel = 3'h0, cpu_div_active;
    logic cpu_clk_tick, periph_clk_tick, cpu_source_status, crystal_osc_en, internal_ring_oscillator_en, cpu_clock_held;
    logic watchdog_reset_req;
    int bad_count = 0, checked = 0, seed = 89741, n, g;
    ////////////////////////////////
    dcs_clock_switch #(.WDOG_OVERFLOW(16'h0010)) dut_u (.clk, .arst_n, .crystal_clk_pin, .ring_clk_pin,
        .ring_stoppable_opt, .cpu_source_select, .crystal_stop_ctrl, .ring_stop_ctrl, .cpu_div_sel, .stop_enter,
        .stop_release_irq, .halt_mode, .stab_wait_done, .watchdog_clear, .cpu_clk_tick, .periph_clk_tick,
        .cpu_source_status, .cpu_div_active, .crystal_osc_en, .internal_ring_oscillator_en, .cpu_clock_held, .watchdog_reset_req);
    always #2 clk = ~clk;
    // Odd-ns toggles never meet a clk edge
    initial begin
        #1;
        forever #20 ring_clk_pin = internal_ring_oscillator_en & ~ring_clk_pin;
    end
    initial begin
        #1;
        forever #12 crystal_clk_pin = crystal_osc_en & ~crystal_clk_pin;
    end
    always @(negedge clk) watchdog_clear <= wd_auto & (($random(seed) & 7) == 0);
    ////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s exp %0d got %0d", nm, e, s);
        end
    endtask
    function automatic logic [2:0] pick(input int sel);
        case (sel)
            0: return {2'h0, cpu_clock_held};
            1: return {2'h0, cpu_source_status};
            2: return {2'h0, cpu_clk_tick};
            3: return {2'h0, watchdog_reset_req};
            default: return cpu_div_active;
        endcase
    endfunction
    task automatic wait_for(input int sel, input logic [2:0] v, input int lim);
        n = 0;
        while (pick(sel) !== v) begin
            @(negedge clk);
            n++;
            if (n > lim) begin
                cmp("wait", v, 3'h7);
                print_verdict();
            end
        end
    endtask
    task automatic gap();
        wait_for(2, 3'h1, 400);
        @(negedge clk);
        wait_for(2, 3'h1, 400);
        g = n + 1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask
    ////////////////////////////////
    initial begin
        logic [2:0] e, old;
        logic pr;
        int k;
        repeat (16) @(negedge clk);
        cmp("held rst", 1, cpu_clock_held);
        cmp("osc rst", 0, crystal_osc_en | internal_ring_oscillator_en);
        arst_n = 1'b1;
        k = 0;
        n = 0;
        while (cpu_clock_held === 1'b1 && n < 400) begin
            pr = ring_clk_pin;
            @(negedge clk);
            k += int'(ring_clk_pin & ~pr);
            n++;
        end
        if (n >= 400) begin
            cmp("startup wait", 1, 0);
            print_verdict();
        end
        cmp("startup edges", 17, k);
        cmp("src rst", 0, cpu_source_status);
        old = 3'h0;
        for (int i = 0; i < 6; i++) begin
            cpu_div_sel = 3'(i);
            e = (i > 4) ? 3'h4 : 3'(i);
            wait_for(4, e, 400);
            cmp("div delay", 1, n <= (RP << old) + 6);
            gap();
            cmp("cpu period", RP << e, g);
            old = e;
        end
        cpu_div_sel = 3'h0;
        wait_for(4, 3'h0, 400);
        stab_wait_done = 1'b1;
        cpu_source_select = 1'b1;
        ring_stop_ctrl = 1'b1;
        wait_for(1, 3'h1, 400);
        cmp("to xtal", 1, n <= 2 * RP + 8);
        crystal_stop_ctrl = 1'b1;
        gap();
        cmp("xtal period", XP, g);
        cmp("xtal kept", 1, crystal_osc_en);
        cmp("ring kept", 1, internal_ring_oscillator_en);
        crystal_stop_ctrl = 1'b0;
        ring_stop_ctrl = 1'b0;
        stab_wait_done = 1'b0;
        pulse(stop_enter);
        // Enable follows the state register by one cycle
        @(negedge clk);
        cmp("xtal stop", 0, crystal_osc_en);
        pulse(stop_release_irq);
        repeat (20) @(negedge clk);
        cmp("stab wait", 1, cpu_clock_held);
        stab_wait_done = 1'b1;
        wait_for(0, 3'h0, 10);
        cmp("resume xtal", 1, cpu_source_status);
        cpu_source_select = 1'b0;
        wait_for(1, 3'h0, 400);
        cmp("to ring", 1, n <= RP + XP + 6);
        crystal_stop_ctrl = 1'b1;
        repeat (3) @(negedge clk);
        cmp("xtal off", 0, crystal_osc_en);
        crystal_stop_ctrl = 1'b0;
        halt_mode = 1'b1;
        repeat (3) @(negedge clk);
        n = 0;
        g = 0;
        repeat (60) begin
            @(negedge clk);
            n += int'(cpu_clk_tick === 1'b1);
            g += int'(periph_clk_tick === 1'b1);
        end
        cmp("halt cpu", 0, n);
        cmp("halt periph", 60 / RP, g);
        halt_mode = 1'b0;
        wd_auto = 1'b0;
        pulse(stop_enter);
        wait_for(3, 3'h1, 400);
        cmp("wdog stop", 1, n >= 9 * RP && n <= 17 * RP + 8);
        pulse(stop_release_irq);
        wait_for(0, 3'h0, 10);
        cmp("resume ring", 0, cpu_source_status);
        // Second reset: ring may now be stopped
        arst_n = 1'b0;
        ring_stoppable_opt = 1'b1;
        wd_auto = 1'b1;
        repeat (4) @(negedge clk);
        cmp("req rst", 0, watchdog_reset_req);
        arst_n = 1'b1;
        wait_for(0, 3'h0, 400);
        wd_auto = 1'b0;
        pulse(stop_enter);
        repeat (300) @(negedge clk);
        cmp("wdog idle", 0, watchdog_reset_req);
        pulse(stop_release_irq);
        wd_auto = 1'b1;
        cpu_source_select = 1'b1;
        wait_for(1, 3'h1, 400);
        ring_stop_ctrl = 1'b1;
        repeat (3) @(negedge clk);
        cmp("ring off", 0, internal_ring_oscillator_en);
        print_verdict();
    end
endmodule
bind dcs_clock_switch dcs_clock_switch_asserts chk_u (.clk, .arst_n, .ring_stoppable_opt, .cpu_source_select,
    .stop_enter, .halt_mode, .cpu_clk_tick, .periph_clk_tick, .cpu_source_status, .crystal_osc_en, .internal_ring_oscillator_en,
    .cpu_clock_held, .watchdog_reset_req);
`default_nettype wire
